/* swc_cfg.svh */
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SWC_ADDR_CTRL 4'h0
`define SWC_ADDR_WAKE_EN 4'h1
`define SWC_ADDR_STATUS 4'h2

`define SWC_CTRL_WDOG_EN 0
`define SWC_CTRL_XTAL 1
`define SWC_CTRL_EXTRST_EN 2
`define SWC_CTRL_GLOBAL_IE 3
`define SWC_CTRL_W 4
`define SWC_CTRL_RST 4'h0
`define SWC_WAKE_EN_RST 8'h00

`define SWC_STAT_TIMEOUT 0
`define SWC_STAT_POWER_DOWN 1
`define SWC_STAT_STATE_LO 2
`define SWC_STAT_STATE_HI 4

// ----------------------------------------
// Wake source positions
// ----------------------------------------
`define SWC_SRC_TIMER_ONE 0
`define SWC_SRC_USART_RX 1
`define SWC_SRC_ADC 2
`define SWC_SRC_PIN_CHANGE 3
`define SWC_SRC_EXT_IRQ_PIN 4
`define SWC_SRC_CAPTURE_ONE 5
`define SWC_SRC_CAPTURE_TWO 6
`define SWC_SRC_SERIAL 7
`define SWC_NUM_SRC 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define SWC_CLK_NS 10
`define SWC_TOSC_NS 10
`define SWC_OST_TOSC 1024
`define SWC_WDOG_CYCLES 18000
`define SWC_VECTOR_ADDR 13'h0004

`endif

/* swc_pkg.sv */
`default_nettype none

package swc_pkg;

    typedef enum logic [2:0] {
        swc_st_run = 3'h0,
        swc_st_sleep = 3'h1,
        swc_st_start = 3'h2,
        swc_st_resume = 3'h3,
        swc_st_vector = 3'h4
    } swc_state_t;

endpackage : swc_pkg

`default_nettype wire

/* swc_sleep_wake.sv */
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "swc_cfg.svh"

// Notes on behaviour
// - Sleep is entered only by the sleep instruction, never by writes.
// - Sleep entry clears the watchdog, which keeps running while asleep.
// - Sleep entry clears the power-down flag and sets the time-out flag.
// - Main oscillator driver off in sleep; timer-one oscillator keeps running.
// - I/O pins hold their pre-sleep state throughout sleep.
// - Watchdog reset never drives the external reset pin low.
// - Wake on reset pin, watchdog (if enabled) or enabled interrupt.
// - Power-down flag set at power-up; watchdog wake clears time-out flag.
// - Listed asynchronous-capable peripheral interrupts can wake the device.
// - Clocked peripherals cannot raise wake interrupts during sleep.
// - The next instruction is prefetched while sleep executes.
// - Wake needs the source enable, not the global interrupt enable.
// - After wake run prefetched instruction, then vector if global enable.
// - Every interrupt or watchdog wake-up clears the watchdog; reset-pin wake does not.
// - Pending enabled flag before sleep makes sleep a no-op.
// - Flag arriving during sleep: complete sleep fully, then wake at once.
// - Crystal modes wait 1024 oscillator periods after wake.
module swc_sleep_wake #(
    parameter int unsigned WDOG_CYCLES = `SWC_WDOG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic external_reset_pin_n,
    input wire logic [7:0] irq_flags,
    input wire logic timer_one_async,
    input wire logic usart_sync_slave,
    input wire logic adc_rc_clock,
    input wire logic sync_serial_port_slave,
    output logic wake_request,
    output logic osc_driver_en,
    output logic timer_one_osc_en,
    output logic io_hold,
    output logic core_halt,
    output logic prefetch_next,
    output logic exec_prefetched,
    output logic vector_request,
    output logic [12:0] vector_address,
    output logic device_reset,
    output logic external_reset_pin_oe_n,
    output logic watchdog_clear,
    output logic watchdog_running,
    output logic sleep_was_nop,
    output logic timeout_flag,
    output logic power_down_flag
);

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int OST_NS = `SWC_OST_TOSC * `SWC_TOSC_NS;
    localparam int OST_CYC = (OST_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS;
    localparam logic [10:0] OST_LAST = 11'(OST_CYC - 1);

    function automatic logic wake_or(
        input logic [7:0] flags,
        input logic [7:0] en,
        input logic [7:0] ok
    );
        wake_or = |(flags & en & ok);
    endfunction : wake_or

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    swc_pkg::swc_state_t state;
    swc_pkg::swc_state_t next_state;
    logic [`SWC_CTRL_W-1:0] ctrl;
    logic [7:0] wake_en, wake_ok;
    logic pend_any, pend_q, pin_s1, pin_s2, pin_s3, pin_lvl;
    logic ext_rst, dog_en, dog_timeout, dog_wake, dog_clr, entry, wake_ev;
    logic [10:0] ost_cnt;

    assign dog_en = ctrl[`SWC_CTRL_WDOG_EN];
    assign dog_wake = dog_en && dog_timeout;
    assign ext_rst = ctrl[`SWC_CTRL_EXTRST_EN] && !pin_lvl;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    // status is read-only
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl <= `SWC_CTRL_RST;
        end else if (reg_wr && reg_addr == `SWC_ADDR_CTRL) begin
            ctrl <= reg_wdata[`SWC_CTRL_W-1:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wake_en <= `SWC_WAKE_EN_RST;
        end else if (reg_wr && reg_addr == `SWC_ADDR_WAKE_EN) begin
            wake_en <= reg_wdata;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `SWC_ADDR_CTRL: reg_rdata <= 8'(ctrl);
                `SWC_ADDR_WAKE_EN: reg_rdata <= wake_en;
                `SWC_ADDR_STATUS: begin
                    reg_rdata <= 8'h00;
                    reg_rdata[`SWC_STAT_TIMEOUT] <= timeout_flag;
                    reg_rdata[`SWC_STAT_POWER_DOWN] <= power_down_flag;
                    reg_rdata[`SWC_STAT_STATE_HI:`SWC_STAT_STATE_LO]
                        <= state;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Reset pin synchroniser
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            {pin_s3, pin_s2, pin_s1} <= 3'h7;
        end else begin
            {pin_s3, pin_s2, pin_s1} <= {pin_s2, pin_s1, external_reset_pin_n};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_lvl <= 1'b1;
        end else if (pin_s2 == pin_s3) begin
            pin_lvl <= pin_s3;
        end
    end

    // ----------------------------------------
    // Wake request
    // ----------------------------------------
    // asynchronous-capable sources
    always_comb begin
        wake_ok = 8'hff;
        wake_ok[`SWC_SRC_TIMER_ONE] = timer_one_async;
        wake_ok[`SWC_SRC_USART_RX] = usart_sync_slave;
        wake_ok[`SWC_SRC_ADC] = adc_rc_clock;
        wake_ok[`SWC_SRC_SERIAL] = sync_serial_port_slave;
    end

    assign pend_any = wake_or(irq_flags, wake_en, 8'hff);
    assign wake_request = wake_or(irq_flags, wake_en, wake_ok);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_any;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // entry only by instruction
    assign entry = state == swc_pkg::swc_st_run && sleep_exec && !pend_q
        && !ext_rst;
    assign wake_ev = state == swc_pkg::swc_st_sleep && !ext_rst
        && (wake_request || dog_wake);

    always_comb begin
        next_state = state;
        case (state)
            swc_pkg::swc_st_run: next_state = entry
                ? swc_pkg::swc_st_sleep : swc_pkg::swc_st_run;
            swc_pkg::swc_st_sleep: next_state = !wake_ev ? state
                : ctrl[`SWC_CTRL_XTAL] ? swc_pkg::swc_st_start
                : swc_pkg::swc_st_resume;
            swc_pkg::swc_st_start: next_state = ost_cnt == OST_LAST
                ? swc_pkg::swc_st_resume : swc_pkg::swc_st_start;
            swc_pkg::swc_st_resume: next_state = ctrl[`SWC_CTRL_GLOBAL_IE]
                ? swc_pkg::swc_st_vector : swc_pkg::swc_st_run;
            swc_pkg::swc_st_vector: next_state = swc_pkg::swc_st_run;
            default: next_state = swc_pkg::swc_st_run;
        endcase
        if (ext_rst) begin
            next_state = swc_pkg::swc_st_run;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= swc_pkg::swc_st_run;
        end else begin
            state <= next_state;
        end
    end
    always_ff @(posedge ref_clk) begin
        ost_cnt <= (!rstn || state != swc_pkg::swc_st_start) ? 11'h000
            : ost_cnt + 11'h001;
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            power_down_flag <= 1'b1;
            timeout_flag <= 1'b1;
        end else if (entry) begin
            power_down_flag <= 1'b0;
            timeout_flag <= 1'b1;
        end else if (!ext_rst && dog_timeout
            && (state == swc_pkg::swc_st_run || dog_wake)) begin
            timeout_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    // clear sources
    assign dog_clr = entry || wake_ev || watchdog_clear_instruction;

    swc_watchdog #(.TIMEOUT(WDOG_CYCLES)) u_watchdog (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(dog_en),
        .clear(dog_clr),
        .timeout(dog_timeout)
    );

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            watchdog_clear <= 1'b0;
            sleep_was_nop <= 1'b0;
            device_reset <= 1'b0;
            vector_address <= 13'h0000;
        end else begin
            watchdog_clear <= dog_clr;
            // pending flag turns sleep into no-op
            sleep_was_nop <= state == swc_pkg::swc_st_run && sleep_exec
                && pend_q;
            device_reset <= ext_rst
                || (state == swc_pkg::swc_st_run && dog_timeout);
            vector_address <= `SWC_VECTOR_ADDR;
        end
    end

    // ----------------------------------------
    // Core and pad controls
    // ----------------------------------------
    // watchdog runs in every state
    assign watchdog_running = dog_en;
    assign osc_driver_en = state != swc_pkg::swc_st_sleep;
    assign timer_one_osc_en = 1'b1;
    assign io_hold = state == swc_pkg::swc_st_sleep
        || state == swc_pkg::swc_st_start;
    assign core_halt = io_hold;
    assign prefetch_next = state == swc_pkg::swc_st_run && sleep_exec;
    assign exec_prefetched = state == swc_pkg::swc_st_resume;
    assign vector_request = state == swc_pkg::swc_st_vector;
    assign external_reset_pin_oe_n = 1'b1;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_enter;
        state == swc_pkg::swc_st_run && sleep_exec && !pend_q && !ext_rst;
    endsequence
    sequence s_entered;
        state == swc_pkg::swc_st_sleep && !power_down_flag && timeout_flag
            && watchdog_clear;
    endsequence
    property p_only_instr;
        state == swc_pkg::swc_st_sleep && $past(state) != state
            |-> $past(sleep_exec);
    endproperty
    a_only_instr: assert property (p_only_instr)
        else $error("sleep entered without instruction");
    property p_entry;
        s_enter |=> s_entered;
    endproperty
    a_entry: assert property (p_entry)
        else $error("sleep entry flags or clear wrong");
    property p_nop;
        state == swc_pkg::swc_st_run && sleep_exec && pend_q && !ext_rst
            |=> state == swc_pkg::swc_st_run && sleep_was_nop
            && !watchdog_clear && power_down_flag == $past(power_down_flag);
    endproperty
    a_nop: assert property (p_nop)
        else $error("pending flag did not make sleep a no-op");
    property p_osc;
        state == swc_pkg::swc_st_sleep |-> !osc_driver_en
            && timer_one_osc_en && io_hold;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator or pad hold wrong in sleep");
    property p_pin;
        device_reset |-> external_reset_pin_oe_n;
    endproperty
    a_pin: assert property (p_pin)
        else $error("reset pin driven");
    property p_dog_wake;
        state == swc_pkg::swc_st_sleep && dog_wake && !ext_rst
            |=> !timeout_flag && watchdog_clear
            && state != swc_pkg::swc_st_sleep;
    endproperty
    a_dog_wake: assert property (p_dog_wake)
        else $error("watchdog wake mishandled");
    property p_irq_wake;
        state == swc_pkg::swc_st_sleep && wake_request && !ext_rst
            |=> watchdog_clear && state != swc_pkg::swc_st_sleep;
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("interrupt wake mishandled");
    sequence s_start_begin;
        state == swc_pkg::swc_st_sleep ##1 state == swc_pkg::swc_st_start;
    endsequence
    // Reset pin may legally cut the start-up delay short
    property p_ost;
        disable iff (!rstn || ext_rst)
        s_start_begin |-> (state == swc_pkg::swc_st_start)[*8];
    endproperty
    a_ost: assert property (p_ost)
        else $error("start-up delay cut short");
    property p_vector;
        exec_prefetched && !ext_rst
            |=> vector_request == $past(ctrl[`SWC_CTRL_GLOBAL_IE]);
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector decision wrong after wake");
    property p_prefetch;
        prefetch_next && !ext_rst |=> state == swc_pkg::swc_st_sleep
            || sleep_was_nop;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("prefetch not followed by sleep or no-op");
endmodule : swc_sleep_wake

`default_nettype wire

/* swc_watchdog.sv */
`timescale 1ns/1ns
`default_nettype none
`include "swc_cfg.svh"

module swc_watchdog #(
    parameter int unsigned TIMEOUT = `SWC_WDOG_CYCLES,
    parameter int unsigned CW = $clog2(TIMEOUT) + 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic clear,
    output logic timeout
);

    // ----------------------------------------
    // Prescaler, count and postscaler as one
    // ----------------------------------------
    localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

    logic [CW-1:0] count;

    always_ff @(posedge ref_clk) begin
        if (!rstn || clear || !enable) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn || clear || !enable) begin
            timeout <= 1'b0;
        end else begin
            timeout <= (count == LAST);
        end
    end

endmodule : swc_watchdog

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "swc_cfg.svh"

module tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_exec = 1'b0;
    logic wd_clr_ins = 1'b0;
    logic pin_n = 1'b1;
    logic [7:0] irq_flags = 8'h00;
    logic [7:0] qual = 8'hff;
    logic [7:0] reg_rdata;
    logic wake_request, osc_driver_en, timer_one_osc_en, io_hold, core_halt;
    logic prefetch_next, exec_prefetched, vector_request, device_reset;
    logic [12:0] vector_address;
    logic external_reset_pin_oe_n, watchdog_clear, watchdog_running;
    logic sleep_was_nop, timeout_flag, power_down_flag;
    logic exp_pd = 1'b1;
    logic exp_to = 1'b1;
    logic [31:0] seed = 32'h55d5;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    always #5 ref_clk = ~ref_clk;

    swc_sleep_wake #(.WDOG_CYCLES(40)) swc_sleep_wake_inst (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
        .watchdog_clear_instruction(wd_clr_ins),
        .external_reset_pin_n(pin_n), .irq_flags(irq_flags),
        .timer_one_async(qual[0]), .usart_sync_slave(qual[1]),
        .adc_rc_clock(qual[2]), .sync_serial_port_slave(qual[7]),
        .wake_request(wake_request), .osc_driver_en(osc_driver_en),
        .timer_one_osc_en(timer_one_osc_en), .io_hold(io_hold),
        .core_halt(core_halt), .prefetch_next(prefetch_next),
        .exec_prefetched(exec_prefetched), .vector_request(vector_request),
        .vector_address(vector_address), .device_reset(device_reset),
        .external_reset_pin_oe_n(external_reset_pin_oe_n),
        .watchdog_clear(watchdog_clear), .watchdog_running(watchdog_running),
        .sleep_was_nop(sleep_was_nop), .timeout_flag(timeout_flag),
        .power_down_flag(power_down_flag)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask : rd

    // Mode 0 plain, 1 flag pending before, 2 flag rising with sleep
    task automatic do_sleep(input int mode);
        @(posedge ref_clk);
        sleep_exec <= 1'b1;
        if (mode == 2) irq_flags <= 8'h10;
        #1 chk("prefetch_next", 1, prefetch_next);
        @(posedge ref_clk);
        sleep_exec <= 1'b0;
        #1;
        if (mode != 1) begin
            exp_pd = 1'b0;
            exp_to = 1'b1;
        end
        chk("sleep_was_nop", mode == 1, sleep_was_nop);
        chk("watchdog_clear", mode != 1, watchdog_clear);
        chk("osc_driver_en", mode == 1, osc_driver_en);
        chk("io_hold", mode != 1, io_hold);
        chk("timer_one_osc_en", 1, timer_one_osc_en);
        chk("power_down_flag", exp_pd, power_down_flag);
        chk("timeout_flag", exp_to, timeout_flag);
    endtask : do_sleep

    task automatic resume_chk(input logic global_interrupt_enable);
        #1 chk("exec_prefetched", 1, exec_prefetched);
        chk("watchdog_clear", 1, watchdog_clear);
        chk("osc_driver_en", 1, osc_driver_en);
        @(posedge ref_clk);
        #1 chk("vector_request", global_interrupt_enable, vector_request);
        if (global_interrupt_enable) chk("vector_address", `SWC_VECTOR_ADDR, vector_address);
        @(posedge ref_clk);
        #1 chk("core_halt", 0, core_halt);
    endtask : resume_chk

    task automatic wake_src(input int i, input logic global_interrupt_enable);
        logic [7:0] b;
        logic q;
        b = 8'h01 << i;
        q = (b & 8'h87) != 8'h00;
        rd(`SWC_ADDR_STATUS, 8'h05);
        @(posedge ref_clk);
        seed = xorshift(seed);
        irq_flags <= seed[7:0] & ~b;
        #1 chk("wake_request", 0, wake_request);
        @(posedge ref_clk);
        irq_flags <= b;
        if (q) qual <= ~b;
        #1 chk("osc_driver_en", 0, osc_driver_en);
        chk("wake_request", !q, wake_request);
        if (q) begin
            @(posedge ref_clk);
            qual <= 8'hff;
            #1 chk("wake_request", 1, wake_request);
        end
        @(posedge ref_clk);
        irq_flags <= 8'h00;
        resume_chk(global_interrupt_enable);
    endtask : wake_src

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    always @(negedge ref_clk) begin
        if (rstn) chk("pin_oe_n", 1, external_reset_pin_oe_n);
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`SWC_ADDR_CTRL, 8'h00);
        rd(`SWC_ADDR_WAKE_EN, 8'h00);
        rd(`SWC_ADDR_STATUS, 8'h03);
        seed = xorshift(seed);
        wr(4'hf, seed[7:0]);
        rd(4'hf, 8'h00);
        wr(`SWC_ADDR_STATUS, 8'h00);
        wr(`SWC_ADDR_CTRL, 8'hff);
        rd(`SWC_ADDR_CTRL, 8'h0f);
        wr(`SWC_ADDR_CTRL, 8'h00);
        wr(`SWC_ADDR_WAKE_EN, seed[15:8]);
        rd(`SWC_ADDR_WAKE_EN, seed[15:8]);
        rd(`SWC_ADDR_STATUS, 8'h03);
        #1 chk("osc_driver_en", 1, osc_driver_en);
        wr(`SWC_ADDR_WAKE_EN, 8'h10);
        @(posedge ref_clk);
        irq_flags <= 8'h10;
        repeat (2) @(posedge ref_clk);
        do_sleep(1);
        @(posedge ref_clk);
        irq_flags <= 8'h00;
        rd(`SWC_ADDR_STATUS, 8'h03);
        do_sleep(2);
        chk("wake_request", 1, wake_request);
        @(posedge ref_clk);
        irq_flags <= 8'h00;
        resume_chk(1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(`SWC_ADDR_CTRL, {4'h0, i[0], 3'h0});
            wr(`SWC_ADDR_WAKE_EN, 8'h01 << i);
            do_sleep(0);
            wake_src(i, i[0]);
        end
        wr(`SWC_ADDR_WAKE_EN, 8'h00);
        wr(`SWC_ADDR_CTRL, 8'h01);
        @(posedge ref_clk);
        wd_clr_ins <= 1'b1;
        @(posedge ref_clk);
        wd_clr_ins <= 1'b0;
        #1 chk("watchdog_clear", 1, watchdog_clear);
        chk("watchdog_running", 1, watchdog_running);
        do_sleep(0);
        n = 0;
        while (osc_driver_en !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("watchdog wake late", 1, n > 20);
        exp_to = 1'b0;
        chk("timeout_flag", exp_to, timeout_flag);
        chk("watchdog_clear", 1, watchdog_clear);
        chk("exec_prefetched", 1, exec_prefetched);
        n = 0;
        while (device_reset !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("device_reset", 1, device_reset);
        chk("timeout_flag", 0, timeout_flag);
        wr(`SWC_ADDR_CTRL, 8'h02);
        wr(`SWC_ADDR_WAKE_EN, 8'h08);
        do_sleep(0);
        @(posedge ref_clk);
        irq_flags <= 8'h08;
        @(posedge ref_clk);
        irq_flags <= 8'h00;
        #1 chk("core_halt", 1, core_halt);
        n = 0;
        while (exec_prefetched !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("start cycles", `SWC_OST_TOSC, n[15:0]);
        wr(`SWC_ADDR_CTRL, 8'h04);
        wr(`SWC_ADDR_WAKE_EN, 8'h00);
        do_sleep(0);
        @(posedge ref_clk);
        pin_n <= 1'b0;
        n = 0;
        while (device_reset !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("device_reset", 1, device_reset);
        @(posedge ref_clk);
        pin_n <= 1'b1;
        #1 chk("core_halt", 0, core_halt);
        repeat (8) @(posedge ref_clk);
        rd(`SWC_ADDR_STATUS, {6'h00, exp_pd, exp_to});
        conclude();
    end
endmodule : tb_top

`default_nettype wire
